/* File: hdl/dtm_timer_ctrl.sv */
// dual timer/counter with mode register, run/flag control register and count bytes
`timescale 1ns/1ps
`default_nettype none
module dtm_timer_ctrl (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [7:0] sfrAddr,
  input  wire logic       sfrWrEn,
  input  wire logic [7:0] sfrWrData,
  input  wire logic       sfrRdEn,
  output logic      [7:0] sfrRdData,
  input  wire logic [7:0] bitAddr,
  input  wire logic       bitWrEn,
  input  wire logic       bitWrVal,
  input  wire logic       timerACountPin,
  input  wire logic       timerBCountPin,
  input  wire logic       extIrqAPin,
  input  wire logic       extIrqBPin,
  input  wire logic       vecAckTimerA,
  input  wire logic       vecAckTimerB,
  input  wire logic       vecAckExtA,
  input  wire logic       vecAckExtB,
  output logic      [7:0] timerRunFlagControl,
  output logic      [7:0] timerModeConfiguration
);

  dtm_pkg::dtm_tctrl_s tctrlReg;
  dtm_pkg::dtm_tctrl_s tctrlNext;
  dtm_pkg::dtm_tmode_s tmodeReg;
  logic [7:0]          timerALowByteReg;
  logic [7:0]          timerAHighByteReg;
  logic [7:0]          timerBLowByteReg;
  logic [7:0]          timerBHighByteReg;
  logic [3:0]          pinSync;
  logic [3:0]          pinSyncDly;

  // pin order: count A, count B, irq A, irq B; all pass two flops first
  dtm_sync #(
    .W (4)
  ) u_sync (
    .clk       (clk),
    .nrst      (nrst),
    .async     ({extIrqBPin, extIrqAPin, timerBCountPin, timerACountPin}),
    .synced    (pinSync),
    .syncedDly (pinSyncDly)
  );

  // one count step; returns {overflow, high byte, low byte}
  function automatic logic [16:0] countStep(
    input logic [1:0] mode,
    input logic [7:0] lo,
    input logic [7:0] hi,
    input logic       inc
  );
    logic [16:0] res;
    res = {1'b0, hi, lo};
    if (inc)
    begin
      case (mode)
        dtm_pkg::MODE_PRESCALE:
        begin
          // upper three low-byte bits are left alone; only the prescaler moves
          if (lo[dtm_pkg::PRESCALE_BITS-1:0] == dtm_pkg::PRESCALE_TOP)
          begin
            res[4:0]  = 5'h00;
            res[15:8] = hi + 8'h01;
            res[16]   = (hi == dtm_pkg::BYTE_TOP);
          end
          else
          begin
            res[4:0] = lo[4:0] + 5'h01;
          end
        end
        dtm_pkg::MODE_WIDE:
        begin
          res[15:0] = {hi, lo} + 16'h0001;
          res[16]   = ({hi, lo} == 16'hFFFF);
        end
        dtm_pkg::MODE_RELOAD:
        begin
          // high byte is the reload value and is never changed here
          res[7:0] = (lo == dtm_pkg::BYTE_TOP) ? hi : lo + 8'h01;
          res[16]  = (lo == dtm_pkg::BYTE_TOP);
        end
        dtm_pkg::MODE_SPLIT:
        begin
          res[7:0] = lo + 8'h01;
          res[16]  = (lo == dtm_pkg::BYTE_TOP);
        end
        default:
        begin
          res = {1'b0, hi, lo};
        end
      endcase
    end
    return res;
  endfunction

  // synchronised pin views
  wire countAFall = pinSyncDly[0] & ~pinSync[0];
  wire countBFall = pinSyncDly[1] & ~pinSync[1];
  wire irqAHigh   = pinSync[2];
  wire irqBHigh   = pinSync[3];
  wire [1:0] irqFall = pinSyncDly[3:2] & ~pinSync[3:2];
  wire [1:0] irqLow  = ~pinSync[3:2];

  // count enables; a cleared run bit stops steps and counts hold, but timer B ignores trB while timer A is in split mode
  wire splitA   = (tmodeReg.modeA == dtm_pkg::MODE_SPLIT);
  wire srcA     = tmodeReg.ctA ? countAFall : 1'b1;
  wire gateOkA  = ~tmodeReg.gateA | irqAHigh;
  wire incA     = tctrlReg.trA & gateOkA & srcA;
  wire srcB     = tmodeReg.ctB ? countBFall : 1'b1;
  wire gateOkB  = ~tmodeReg.gateB | irqBHigh;
  wire runB     = splitA ? 1'b1 : (tctrlReg.trB & gateOkB);
  wire incB     = (tmodeReg.modeB != dtm_pkg::MODE_SPLIT) & runB & srcB;
  wire incAHigh = splitA & tctrlReg.trB;

  // next counts for both timers
  wire [16:0] stepA = countStep(tmodeReg.modeA, timerALowByteReg, timerAHighByteReg, incA);
  wire [16:0] stepB = countStep(tmodeReg.modeB, timerBLowByteReg, timerBHighByteReg, incB);
  wire [7:0]  highANext = splitA ? timerAHighByteReg + {7'h00, incAHigh}
                                 : stepA[15:8];
  wire        ovfAHigh  = incAHigh & (timerAHighByteReg == dtm_pkg::BYTE_TOP);
  wire        ovfA      = stepA[16];
  // in split mode the timer A high byte owns timer B's flag
  wire        ovfB      = splitA ? ovfAHigh : stepB[16];

  // register write decode
  wire wrTctrl = sfrWrEn & (sfrAddr == dtm_pkg::ADDR_TCTRL);
  wire wrTmode = sfrWrEn & (sfrAddr == dtm_pkg::ADDR_TMODE);
  wire wrALow  = sfrWrEn & (sfrAddr == dtm_pkg::ADDR_TA_LOW);
  wire wrAHigh = sfrWrEn & (sfrAddr == dtm_pkg::ADDR_TA_HIGH);
  wire wrBLow  = sfrWrEn & (sfrAddr == dtm_pkg::ADDR_TB_LOW);
  wire wrBHigh = sfrWrEn & (sfrAddr == dtm_pkg::ADDR_TB_HIGH);
  wire bitHit  = bitWrEn & (bitAddr[7:3] == dtm_pkg::ADDR_TCTRL[7:3]);
  wire [7:0] bitMask = 8'h01 << bitAddr[2:0];

  // software view of the control register after byte or bit writes
  wire [7:0] swTctrl = wrTctrl ? sfrWrData
                     : bitHit  ? ((tctrlReg & ~bitMask) | (bitWrVal ? bitMask : 8'h00))
                     : tctrlReg;

  // flag handling: hardware set beats vector clear and software clear
  logic [1:0] ieNext;
  wire  [1:0] itSw  = {swTctrl[2], swTctrl[0]};
  wire  [1:0] ieSw  = {swTctrl[3], swTctrl[1]};
  wire  [1:0] ackEx = {vecAckExtB, vecAckExtA};

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_ext
      // level mode tracks the pin; edge mode latches until vectored
      assign ieNext[g] = itSw[g] ? (irqFall[g] | (ieSw[g] & ~ackEx[g]))
                                 : irqLow[g];
    end
  endgenerate

  always_comb
  begin
    tctrlNext     = swTctrl;
    tctrlNext.tfB = ovfB | (swTctrl[dtm_pkg::BIT_TF_B] & ~vecAckTimerB);
    tctrlNext.tfA = ovfA | (swTctrl[dtm_pkg::BIT_TF_A] & ~vecAckTimerA);
    tctrlNext.ieB = ieNext[1];
    tctrlNext.ieA = ieNext[0];
  end

  // control and mode registers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tctrlReg <= dtm_pkg::TCTRL_RST;
      tmodeReg <= dtm_pkg::TMODE_RST;
    end
    else
    begin
      tctrlReg <= tctrlNext;
      tmodeReg <= wrTmode ? sfrWrData : tmodeReg;
    end
  end

  // count bytes; a software write wins over a count step in the same cycle
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      timerALowByteReg  <= dtm_pkg::COUNT_RST;
      timerAHighByteReg <= dtm_pkg::COUNT_RST;
      timerBLowByteReg  <= dtm_pkg::COUNT_RST;
      timerBHighByteReg <= dtm_pkg::COUNT_RST;
    end
    else
    begin
      timerALowByteReg  <= wrALow  ? sfrWrData : stepA[7:0];
      timerAHighByteReg <= wrAHigh ? sfrWrData : highANext;
      timerBLowByteReg  <= wrBLow  ? sfrWrData : stepB[7:0];
      timerBHighByteReg <= wrBHigh ? sfrWrData : stepB[15:8];
    end
  end

  // read selection; unmapped addresses return zero
  wire [7:0] rdMux = (sfrAddr == dtm_pkg::ADDR_TCTRL)   ? tctrlReg
                   : (sfrAddr == dtm_pkg::ADDR_TMODE)   ? tmodeReg
                   : (sfrAddr == dtm_pkg::ADDR_TA_LOW)  ? timerALowByteReg
                   : (sfrAddr == dtm_pkg::ADDR_TA_HIGH) ? timerAHighByteReg
                   : (sfrAddr == dtm_pkg::ADDR_TB_LOW)  ? timerBLowByteReg
                   : (sfrAddr == dtm_pkg::ADDR_TB_HIGH) ? timerBHighByteReg
                   : 8'h00;

  // registered outputs; read data holds until the next read strobe
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sfrRdData              <= 8'h00;
      timerRunFlagControl    <= dtm_pkg::TCTRL_RST;
      timerModeConfiguration <= dtm_pkg::TMODE_RST;
    end
    else
    begin
      sfrRdData              <= sfrRdEn ? rdMux : sfrRdData;
      timerRunFlagControl    <= tctrlNext;
      timerModeConfiguration <= wrTmode ? sfrWrData : tmodeReg;
    end
  end

endmodule
`default_nettype wire

/* File: hdl/dtm_pkg.sv */
// package with register map, field layouts and reset values for the dual timer control block
`default_nettype none
package dtm_pkg;

  // special function addresses
  localparam logic [7:0] ADDR_TCTRL   = 8'h88;
  localparam logic [7:0] ADDR_TMODE   = 8'h89;
  localparam logic [7:0] ADDR_TA_LOW  = 8'h8A;
  localparam logic [7:0] ADDR_TB_LOW  = 8'h8B;
  localparam logic [7:0] ADDR_TA_HIGH = 8'h8C;
  localparam logic [7:0] ADDR_TB_HIGH = 8'h8D;

  // reset values
  localparam logic [7:0] TCTRL_RST = 8'h00;
  localparam logic [7:0] TMODE_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;

  // mode field encodings
  localparam logic [1:0] MODE_PRESCALE = 2'h0;
  localparam logic [1:0] MODE_WIDE     = 2'h1;
  localparam logic [1:0] MODE_RELOAD   = 2'h2;
  localparam logic [1:0] MODE_SPLIT    = 2'h3;

  // prescaler width and terminal values
  localparam int         PRESCALE_BITS = 5;
  localparam logic [4:0] PRESCALE_TOP  = 5'h1F;
  localparam logic [7:0] BYTE_TOP      = 8'hFF;

  // bit positions inside the control register
  localparam int BIT_TF_B = 7;
  localparam int BIT_TR_B = 6;
  localparam int BIT_TF_A = 5;
  localparam int BIT_TR_A = 4;

  // control register layout, msb first
  typedef struct packed {
    logic tfB;
    logic trB;
    logic tfA;
    logic trA;
    logic ieB;
    logic itB;
    logic ieA;
    logic itA;
  } dtm_tctrl_s;

  // mode register layout, msb first
  typedef struct packed {
    logic       gateB;
    logic       ctB;
    logic [1:0] modeB;
    logic       gateA;
    logic       ctA;
    logic [1:0] modeA;
  } dtm_tmode_s;

endpackage
`default_nettype wire

/* File: hdl/dtm_sync.sv */
// two flip-flop synchroniser with a delayed copy for edge detection
`timescale 1ns/1ps
`default_nettype none
module dtm_sync #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] async,
  output logic      [W-1:0] synced,
  output logic      [W-1:0] syncedDly
);

  logic [W-1:0] stage1Reg;

  // pins idle high, so reset to ones to avoid a false falling edge
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stage1Reg <= '1;
      synced    <= '1;
      syncedDly <= '1;
    end
    else
    begin
      stage1Reg <= async;
      synced    <= stage1Reg;
      syncedDly <= synced;
    end
  end

endmodule
`default_nettype wire

/* File: tb/dtm_timer_ctrl_checker.sv */
// assertion checker for the dual timer control block
`timescale 1ns/1ps
`default_nettype none
module dtm_timer_ctrl_checker (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [7:0] sfrAddr,
  input  wire logic       sfrWrEn,
  input  wire logic [7:0] sfrWrData,
  input  wire logic [7:0] bitAddr,
  input  wire logic       bitWrEn,
  input  wire logic       bitWrVal,
  input  wire logic       extIrqBPin,
  input  wire logic       vecAckTimerA,
  input  wire logic       vecAckTimerB,
  input  wire logic [7:0] timerRunFlagControl,
  input  wire logic [7:0] timerModeConfiguration
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // decoded writes; flag bits are masked where hardware may set them
  wire logic [7:0] tc    = timerRunFlagControl;
  wire logic       wrCtl = sfrWrEn && sfrAddr == 8'h88;
  wire logic       anyWr = sfrWrEn || bitWrEn;
  // register writes
  a_ctrl_byte_write : assert property (
    wrCtl |=> (tc & 8'h55) == ($past(sfrWrData) & 8'h55)) else $error("control byte lost");
  a_mode_byte_write : assert property (
    sfrWrEn && sfrAddr == 8'h89 |=> timerModeConfiguration == $past(sfrWrData))
    else $error("mode byte lost");
  a_run_a_bit : assert property (
    bitWrEn && !sfrWrEn && bitAddr == 8'h8C |=> tc[4] == $past(bitWrVal)) else $error("run a bit");
  a_run_b_bit : assert property (
    bitWrEn && !sfrWrEn && bitAddr == 8'h8E |=> tc[6] == $past(bitWrVal)) else $error("run b bit");
  a_run_b_only_sw : assert property (
    $changed(tc[6]) |-> $past(wrCtl || (bitWrEn && bitAddr == 8'h8E))) else $error("run b moved");
  // flags: level follows pin, acks clear, overflow needs a running timer
  a_level_follows_pin : assert property (
    (!tc[2] && $stable(extIrqBPin)) [*5] |-> tc[3] == !extIrqBPin) else $error("level flag");
  a_ack_clears_a : assert property (
    vecAckTimerA && !tc[4] && !anyWr |=> !tc[5]) else $error("flag a not cleared");
  a_ack_clears_b : assert property (
    vecAckTimerB && !tc[6] && !anyWr |=> !tc[7]) else $error("flag b not cleared");
  a_flag_a_cause : assert property (
    $rose(tc[5]) |-> $past(tc[4]) || $past(anyWr)) else $error("flag a without run");
  c_flag_a : cover property ($rose(tc[5]));
  c_flag_b : cover property ($rose(tc[7]));
  c_edge_irq : cover property ($rose(tc[3]) && tc[2]);
endmodule
bind dtm_timer_ctrl dtm_timer_ctrl_checker u_chk (.clk, .nrst, .sfrAddr, .sfrWrEn, .sfrWrData,
  .bitAddr, .bitWrEn, .bitWrVal, .extIrqBPin, .vecAckTimerA, .vecAckTimerB,
  .timerRunFlagControl, .timerModeConfiguration);
`default_nettype wire

/* File: tb/dtm_timer_ctrl_tb.sv */
// self-checking bench for the dual timer control block
`timescale 1ns/1ps
`default_nettype none
module dtm_timer_ctrl_tb;
  logic       clk, nrst, sfrWrEn, sfrRdEn, bitWrEn, bitWrVal, rdVld, vecAckExtA;
  logic       timerACountPin, extIrqAPin, extIrqBPin, vecAckTimerA, vecAckTimerB, vecAckExtB;
  logic [7:0] sfrAddr, sfrWrData, bitAddr, sfrRdData, timerRunFlagControl;
  logic [7:0] timerModeConfiguration, d;
  logic [7:0] expQ[$];
  string      nameQ[$];
  int         n_fail, compares;

  dtm_timer_ctrl DUT (.clk, .nrst, .sfrAddr, .sfrWrEn, .sfrWrData, .sfrRdEn, .sfrRdData,
    .bitAddr, .bitWrEn, .bitWrVal, .timerACountPin, .timerBCountPin(1'b1), .extIrqAPin,
    .extIrqBPin, .vecAckTimerA, .vecAckTimerB, .vecAckExtA, .vecAckExtB,
    .timerRunFlagControl, .timerModeConfiguration);

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // a wait of one or more cycles drops every strobe left up by the last request
  task automatic idle(input int n);
    if (n > 0)
      {sfrWrEn, sfrRdEn, bitWrEn} = 3'h0;
    repeat (n) @(negedge clk);
  endtask
  // all requests start at a falling edge and are taken at the next rising one;
  // strobes are set together and left up, so back-to-back calls never touch one twice
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    {sfrAddr, sfrWrData, sfrWrEn, sfrRdEn, bitWrEn} = {a, v, 3'h4};
    @(negedge clk);
  endtask
  task automatic bw(input logic [7:0] a, input logic v);
    {bitAddr, bitWrVal, sfrWrEn, sfrRdEn, bitWrEn} = {a, v, 3'h1};
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    {sfrAddr, sfrWrEn, sfrRdEn, bitWrEn} = {a, 3'h2};
    expQ.push_back(e);
    nameQ.push_back(n);
    @(negedge clk);
  endtask
  // the stop lands k+1 edges after the start, so exactly k+1 counting steps occur
  task automatic run(input logic [7:0] m, lo, hi, ctl, stop, input int k);
    wr(8'h89, m);
    wr(8'h8A, lo);
    wr(8'h8C, hi);
    wr(8'h88, ctl);
    idle(k);
    bw(stop, 1'b0);
  endtask
  task automatic give_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // read data lands at the edge after the strobe; compare it half a cycle later
  always @(posedge clk) rdVld <= sfrRdEn;
  always @(negedge clk)
    if (rdVld)
      check(nameQ.pop_front(), sfrRdData, expQ.pop_front());

  initial
  begin
    repeat (3000) @(posedge clk);
    n_fail++;
    give_verdict();
  end

  initial
  begin
    {nrst, sfrWrEn, sfrRdEn, bitWrEn, bitWrVal, vecAckTimerA, vecAckTimerB, vecAckExtB} = '0;
    // interrupt and count pins idle high so no level request shows in the flag reads
    {sfrAddr, sfrWrData, bitAddr, extIrqAPin, extIrqBPin, timerACountPin} = {24'h0, 3'h7};
    vecAckExtA = 1'b0;
    void'($urandom(32'h9EA6));
    idle(4);
    nrst = 1'b1;
    idle(1);
    rd(8'h88, 8'h00, "ctrl");
    rd(8'h89, 8'h00, "mode");
    wr(8'h87, 8'h55);
    rd(8'h87, 8'h00, "unmapped");
    repeat (3)
    begin
      d = 8'($urandom);
      wr(8'h89, d);
      rd(8'h89, d, "mode");
    end
    run(8'h02, 8'hFF, 8'hFE, 8'h10, 8'h8C, 4);
    rd(8'h8A, 8'hFE, "low");
    rd(8'h8C, 8'hFE, "high");
    rd(8'h88, 8'h20, "ctrl");
    rd(8'h8A, 8'hFE, "low");
    vecAckTimerA = 1'b1;
    idle(1);
    vecAckTimerA = 1'b0;
    rd(8'h88, 8'h00, "ctrl");
    run(8'h01, 8'hFF, 8'hFF, 8'h10, 8'h8C, 0);
    rd(8'h8A, 8'h00, "low");
    rd(8'h8C, 8'h00, "high");
    rd(8'h88, 8'h20, "ctrl");
    run(8'h00, 8'hFF, 8'h05, 8'h10, 8'h8C, 0);
    rd(8'h8A, 8'hE0, "low");
    rd(8'h8C, 8'h06, "high");
    run(8'h03, 8'hFF, 8'hFF, 8'h40, 8'h8E, 0);
    rd(8'h8A, 8'hFF, "low");
    rd(8'h8C, 8'h00, "high");
    rd(8'h88, 8'h80, "ctrl");
    vecAckTimerB = 1'b1;
    idle(1);
    vecAckTimerB = 1'b0;
    rd(8'h88, 8'h00, "ctrl");
    // gated count: pin low holds the timer, pin high lets it run
    extIrqAPin = 1'b0;
    run(8'h09, 8'h00, 8'h00, 8'h10, 8'h8C, 5);
    rd(8'h8A, 8'h00, "low");
    extIrqAPin = 1'b1;
    run(8'h09, 8'h00, 8'h00, 8'h10, 8'h8C, 2);
    rd(8'h8A, 8'h03, "low");
    // counter source: only pin falls count, each level held several clocks
    run(8'h05, 8'h00, 8'h00, 8'h10, 8'h8E, 0);
    repeat (3)
    begin
      timerACountPin = 1'b0;
      idle(3);
      timerACountPin = 1'b1;
      idle(3);
    end
    bw(8'h8C, 1'b0);
    rd(8'h8A, 8'h03, "low");
    extIrqBPin = 1'b0;
    idle(6);
    rd(8'h88, 8'h08, "ctrl");
    extIrqBPin = 1'b1;
    idle(6);
    rd(8'h88, 8'h00, "ctrl");
    // both pins in edge mode; each ack clears only its own flag
    wr(8'h88, 8'h05);
    {extIrqBPin, extIrqAPin} = 2'h0;
    idle(6);
    {extIrqBPin, extIrqAPin} = 2'h3;
    idle(6);
    rd(8'h88, 8'h0F, "ctrl");
    vecAckExtB = 1'b1;
    idle(1);
    vecAckExtB = 1'b0;
    rd(8'h88, 8'h07, "ctrl");
    vecAckExtA = 1'b1;
    idle(1);
    vecAckExtA = 1'b0;
    rd(8'h88, 8'h05, "ctrl");
    idle(3);
    if (expQ.size() != 0)
      n_fail++;
    give_verdict();
  end
endmodule
`default_nettype wire
